/* core/isa_host_bus_interface.sv */
/*
  ISA slave host port: address capture and decode, data bus drive,
  DMA requests, interrupt steering and ready stretching.
  Assumes host strobes, dack, tc and data are asynchronous to mclk and resynchronised here; internal functions
  are outside and reached through the function-side ports.
*/
`timescale 1ns/100ps
module isa_host_bus_interface
  import host_port_pkg::*;
(
  // Clock and reset
  input  wire logic                                  mclk,
  input  wire logic                                  srst,
  // Host address and strobes
  input  wire logic [host_port_pkg::ADDR_W-1:0]      addr,
  input  wire logic                                  ior_n,
  input  wire logic                                  iow_n,
  input  wire logic                                  aen,
  input  wire logic                                  cs_n,
  // Host data bus
  input  wire logic [host_port_pkg::DATA_W-1:0]      data_in,
  output logic      [host_port_pkg::DATA_W-1:0]      data_out,
  output logic                                       data_oe,
  // DMA
  output logic      [host_port_pkg::DMA_CH-1:0]      drq,
  input  wire logic [host_port_pkg::DMA_CH-1:0]      dack_n,
  input  wire logic                                  tc,
  // Interrupts, open-drain capable outputs
  output logic      [host_port_pkg::IRQ_OUTS-1:0]    irq_out,
  output logic      [host_port_pkg::IRQ_OUTS-1:0]    irq_oe,
  input  wire logic                                  external_interrupt_input,
  // Ready, open drain
  output logic                                       iochrdy_out,
  output logic                                       iochrdy_oe,
  // Configuration (kept across srst by the owner)
  input  wire host_port_pkg::tc_mode_t               tc_mode,
  input  wire host_port_pkg::par_mode_t              par_mode,
  input  wire logic [host_port_pkg::IRQ_SRCS*host_port_pkg::IRQ_SEL_W-1:0]
                                                     irq_sel,
  input  wire logic [host_port_pkg::ADDR_W-1:0]      win_base,
  input  wire logic [host_port_pkg::ADDR_W-1:0]      win_mask,
  // Function side
  output logic      [host_port_pkg::ADDR_W-1:0]      fn_addr,
  output logic                                       fn_sel,
  output logic                                       fn_rd_pulse,
  output logic                                       fn_wr_pulse,
  output logic      [host_port_pkg::DATA_W-1:0]      fn_wdata,
  input  wire logic [host_port_pkg::DATA_W-1:0]      fn_rdata,
  input  wire logic [host_port_pkg::IRQ_SRCS-2:0]    fn_irq,
  input  wire logic [host_port_pkg::DMA_CH-1:0]      fn_dma_want,
  input  wire logic [host_port_pkg::DMA_CH-1:0]      fn_dma_last,
  output logic      [host_port_pkg::DMA_CH-1:0]      fn_dma_en,
  output logic      [host_port_pkg::DMA_CH-1:0]      fn_tc,
  input  wire logic                                  ir_wait,
  input  wire logic                                  epp_wait
);
  import host_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [1:0]        ior_s_q;
  logic [1:0]        iow_s_q;
  logic [1:0]        tc_s_q;
  logic [DMA_CH-1:0] dack_s0_q;
  logic [DMA_CH-1:0] dack_s1_q;
  logic              ior_d1_q;
  logic              iow_d1_q;
  logic [DMA_CH-1:0] dack_d1_q;
  logic [DATA_W-1:0] din_s0_q;
  logic [DATA_W-1:0] din_s1_q;

  always_ff @(posedge mclk) begin
    ior_s_q   <= {ior_s_q[0], ior_n};
    iow_s_q   <= {iow_s_q[0], iow_n};
    tc_s_q    <= {tc_s_q[0], tc};
    dack_s0_q <= dack_n;
    dack_s1_q <= dack_s0_q;
    ior_d1_q  <= ior_s_q[1];
    iow_d1_q  <= iow_s_q[1];
    dack_d1_q <= dack_s1_q;
    din_s0_q  <= data_in;
    din_s1_q  <= din_s0_q;
  end

  wire               rd_act   = ~ior_s_q[1];
  wire               wr_act   = ~iow_s_q[1];
  wire               rd_fall  = ior_d1_q & ~ior_s_q[1];
  wire               wr_fall  = iow_d1_q & ~iow_s_q[1];
  wire               rd_rise  = ~ior_d1_q & ior_s_q[1];
  wire               wr_rise  = ~iow_d1_q & iow_s_q[1];
  wire [DMA_CH-1:0]  dack_fall = dack_d1_q & ~dack_s1_q;
  wire               any_dack = ~&dack_s1_q;

  ////////////////////////////////////////////////////////////////////////
  // Address capture and decode
  logic [ADDR_W-1:0] addr_q;
  logic              sel_q;
  logic              rd_q;
  logic              wr_q;
  logic [DATA_W-1:0] wdata_q;

  wire lead_edge = rd_fall | wr_fall;
  // Window match on every address bit, no aliasing
  wire addr_hit  = ((addr ^ win_base) & win_mask) == '0 &&
                   win_mask == {ADDR_W{1'b1}};
  wire io_hit    = addr_hit & ~aen & ~cs_n;

  always_ff @(posedge mclk) begin
    if (lead_edge) begin
      addr_q <= addr;
    end
    if (srst) begin
      sel_q <= 1'b0;
      rd_q  <= 1'b0;
      wr_q  <= 1'b0;
    end else if (lead_edge) begin
      sel_q <= io_hit;
      rd_q  <= rd_fall;
      wr_q  <= wr_fall;
    end else if (rd_rise | wr_rise) begin
      sel_q <= 1'b0;
      rd_q  <= 1'b0;
      wr_q  <= 1'b0;
    end
  end

  // Write data is delayed like the strobe, so the last sample taken
  // before the synchronised trailing edge is still the host's data
  always_ff @(posedge mclk) begin
    if (srst) begin
      wdata_q     <= '0;
      fn_wr_pulse <= 1'b0;
      fn_rd_pulse <= 1'b0;
    end else begin
      fn_wr_pulse <= wr_rise & sel_q & wr_q;
      fn_rd_pulse <= rd_fall & io_hit;
      if (wr_act & sel_q) begin
        wdata_q <= din_s1_q;
      end
    end
  end

  assign fn_addr  = addr_q;
  assign fn_sel   = sel_q;
  assign fn_wdata = wdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Read data drive
  logic [DATA_W-1:0] dout_q;
  logic              doe_q;
  wire               dma_rd = rd_act & any_dack;
  wire               drive  = rd_act & ((sel_q & rd_q) | dma_rd);

  always_ff @(posedge mclk) begin
    if (srst) begin
      doe_q  <= 1'b0;
      dout_q <= '0;
    end else begin
      doe_q  <= drive;
      dout_q <= drive ? fn_rdata : '0;
    end
  end

  assign data_out = dout_q;
  assign data_oe  = doe_q;

  ////////////////////////////////////////////////////////////////////////
  // DMA channels
  wire tc_active = (tc_mode == TC_MODE_PS) ? ~tc_s_q[1]
                                           : tc_s_q[1];
  logic [DMA_CH-1:0] drq_q;

  for (genvar c = 0; c < DMA_CH; c++) begin : g_dma
    dma_channel u_ch (
      .mclk      (mclk),
      .srst      (srst),
      .want_req  (fn_dma_want[c]),
      .last_byte (fn_dma_last[c]),
      .dack_n    (dack_s1_q[c]),
      .dack_fall (dack_fall[c]),
      .rd_fall   (rd_fall),
      .tc_active (tc_active),
      .drq_q     (drq_q[c]),
      .xfer_en   (fn_dma_en[c]),
      .tc_seen_q (fn_tc[c])
    );
  end

  assign drq = drq_q;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt steering
  wire [IRQ_SRCS-1:0] irq_src = {external_interrupt_input, fn_irq};
  wire                share   = (par_mode != PAR_SPP);
  wire [IRQ_SEL_W-1:0] ext_sel =
    irq_sel[EXT_IRQ_SLOT*IRQ_SEL_W +: IRQ_SEL_W];
  logic [IRQ_OUTS-1:0] level_or;
  logic [IRQ_OUTS-1:0] pulse_or;
  logic [IRQ_SRCS-1:0] src_d1_q;
  logic [IRQ_OUTS-1:0] irq_q;
  logic [IRQ_OUTS-1:0] pulse_q;
  logic [2:0]          pcnt_q [IRQ_OUTS];

  always_comb begin
    level_or = '0;
    pulse_or = '0;
    for (int s = 0; s < IRQ_SRCS; s++) begin
      for (int o = 0; o < IRQ_OUTS; o++) begin
        if (irq_sel[s*IRQ_SEL_W +: IRQ_SEL_W] == IRQ_SEL_W'(o)) begin
          if (share && s == PAR_IRQ_SLOT) begin
            pulse_or[o] = pulse_or[o] | (irq_src[s] & ~src_d1_q[s]);
          end else begin
            level_or[o] = level_or[o] | irq_src[s];
          end
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      src_d1_q <= '0;
      pulse_q  <= '0;
      irq_q    <= '0;
      for (int o = 0; o < IRQ_OUTS; o++) begin
        pcnt_q[o] <= '0;
      end
    end else begin
      src_d1_q <= irq_src;
      irq_q    <= level_or;
      for (int o = 0; o < IRQ_OUTS; o++) begin
        if (pulse_or[o]) begin
          pulse_q[o] <= 1'b1;
          pcnt_q[o]  <= '0;
        end else if (pulse_q[o]) begin
          pcnt_q[o]  <= pcnt_q[o] + 3'h1;
          pulse_q[o] <= (pcnt_q[o] != IRQ_PULSE_LAST);
        end
      end
    end
  end

  // Shared pulse drives low; otherwise level drive
  assign irq_out = irq_q & ~pulse_q;
  assign irq_oe  = irq_q | pulse_q;

  ////////////////////////////////////////////////////////////////////////
  // Ready stretching
  logic rdy_low_q;
  wire  may_wait = ir_wait | (epp_wait & (par_mode == PAR_EPP));
  wire  cyc_open = (rd_act | wr_act) & sel_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdy_low_q <= 1'b0;
    end else begin
      rdy_low_q <= cyc_open & may_wait;
    end
  end

  assign iochrdy_out = 1'b0;
  assign iochrdy_oe  = rdy_low_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_rd_open;
    rd_fall && io_hit;
  endsequence
  sequence s_drive_on;
    ##3 data_oe;
  endsequence

  a_bus_idle_hiz: assert property (@(posedge mclk) disable iff (srst)
    (!rd_act && !$past(rd_act)) |-> !data_oe)
    else $error("data bus driven with no read");
  a_read_drives: assert property (@(posedge mclk) disable iff (srst)
    (s_rd_open ##1 rd_act [*3]) |-> data_oe)
    else $error("decoded read not driven");
  a_aen_blocks: assert property (@(posedge mclk) disable iff (srst)
    (lead_edge && aen) |=> !fn_sel)
    else $error("decode during dma cycle");
  a_cs_blocks: assert property (@(posedge mclk) disable iff (srst)
    (lead_edge && cs_n) |=> !fn_sel)
    else $error("decode without chip select");
  a_addr_held: assert property (@(posedge mclk) disable iff (srst)
    (fn_sel && !lead_edge) |=> $stable(fn_addr))
    else $error("captured address moved");
  a_addr_taken: assert property (@(posedge mclk) disable iff (srst)
    lead_edge |=> fn_addr == $past(addr))
    else $error("address not captured at edge");
  a_one_rd_pulse: assert property (@(posedge mclk) disable iff (srst)
    fn_rd_pulse |=> !fn_rd_pulse)
    else $error("read edge seen twice");
  a_ready_owner: assert property (@(posedge mclk) disable iff (srst)
    iochrdy_oe |-> $past(ir_wait || (epp_wait && par_mode == PAR_EPP)))
    else $error("ready pulled by other function");
  a_ready_cycle: assert property (@(posedge mclk) disable iff (srst)
    iochrdy_oe |-> $past(sel_q))
    else $error("ready pulled outside a cycle");
  a_irq_pulse_end: assert property (@(posedge mclk) disable iff (srst)
    $rose(pulse_q[0]) && !pulse_or[0] |-> ##4 !pulse_q[0])
    else $error("shared pulse not released");
  a_irq_route: assert property (@(posedge mclk) disable iff (srst)
    (external_interrupt_input && ext_sel < IRQ_SEL_W'(IRQ_OUTS))
    |=> irq_q[$past(ext_sel)])
    else $error("external interrupt not routed");
  a_tc_polarity: assert property (@(posedge mclk) disable iff (srst)
    (tc_mode == TC_MODE_PS) |-> tc_active == !tc_s_q[1])
    else $error("terminal count polarity wrong");
endmodule : isa_host_bus_interface

/* shared/host_port_pkg.sv */
/*
  Constants and types for the ISA host port block.
  Assumes one 200 MHz clock and a synchronous active-high reset.
*/
package host_port_pkg;
  localparam int unsigned ADDR_W      = 11;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned DMA_CH      = 3;
  localparam int unsigned IRQ_OUTS    = 6;
  localparam int unsigned IRQ_SRCS    = 8;
  localparam int unsigned IRQ_SEL_W   = 3;
  // Interrupt steering selects beyond the output count mean "not routed"
  localparam logic [IRQ_SEL_W-1:0] IRQ_SEL_NONE = 3'h7;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned RESET_MIN_NS  = 500;
  localparam int unsigned RESET_MIN_CYC =
    (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Share pulse width on the interrupt outputs, in clock cycles
  localparam int unsigned IRQ_PULSE_CYC = 4;
  localparam logic [2:0] IRQ_PULSE_LAST = 3'h3;
  // Source slot of the external interrupt input in the steering table
  localparam int unsigned EXT_IRQ_SLOT  = 7;
  localparam int unsigned PAR_IRQ_SLOT  = 3;

  typedef enum logic [1:0] {
    TC_MODE_AT,
    TC_MODE_MODEL30,
    TC_MODE_PS
  } tc_mode_t;

  typedef enum logic [1:0] {
    PAR_SPP,
    PAR_EPP,
    PAR_ECP
  } par_mode_t;
endpackage : host_port_pkg

/* core/dma_channel.sv */
/*
  One DMA request channel: request, acknowledge qualification and
  terminal count capture.
  Assumes synchronised, already edge-detected strobe inputs.
*/
`timescale 1ns/100ps
module dma_channel (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic srst,
  // Function side
  input  wire logic want_req,
  input  wire logic last_byte,
  // Host side, synchronised
  input  wire logic dack_n,
  input  wire logic dack_fall,
  input  wire logic rd_fall,
  input  wire logic tc_active,
  // Results
  output logic      drq_q,
  output logic      xfer_en,
  output logic      tc_seen_q
);
  logic drq_d;
  logic tc_seen_d;
  wire  ack_drop  = last_byte & dack_fall;
  wire  dem_drop  = last_byte & ~dack_n & rd_fall;

  assign xfer_en   = ~dack_n;
  assign drq_d     = (ack_drop | dem_drop) ? 1'b0 : want_req;
  // A new terminal count wins over the clear when both fall together
  assign tc_seen_d = (tc_seen_q & want_req) | (tc_active & ~dack_n);

  always_ff @(posedge mclk) begin
    if (srst) begin
      drq_q     <= 1'b0;
      tc_seen_q <= 1'b0;
    end else begin
      drq_q     <= drq_d;
      tc_seen_q <= tc_seen_d;
    end
  end

  a_drop_on_ack: assert property (@(posedge mclk) disable iff (srst)
    ack_drop |=> !drq_q) else $error("request held after last ack");
  a_drop_on_rd: assert property (@(posedge mclk) disable iff (srst)
    dem_drop |=> !drq_q) else $error("demand request not dropped");
  a_tc_gated: assert property (@(posedge mclk) disable iff (srst)
    (dack_n && !tc_seen_q) |=> !tc_seen_q)
    else $error("terminal count taken without ack");
endmodule : dma_channel

/* verification/host_model.sv */
/*
  Partner model: host processor and DMA controller on the ISA side.
  Assumes the bench calls its tasks; it drives pins on the falling edge.
*/
`timescale 1ns/100ps
module host_model
  import host_port_pkg::*;
(
  // Clock and sensed outputs
  input  wire logic                             mclk,
  input  wire logic [host_port_pkg::DATA_W-1:0] data_out,
  input  wire logic                             data_oe,
  input  wire logic                             iochrdy_oe,
  // Host drive
  output logic      [host_port_pkg::ADDR_W-1:0] addr,
  output logic                                  ior_n,
  output logic                                  iow_n,
  output logic                                  aen,
  output logic                                  cs_n,
  output logic      [host_port_pkg::DATA_W-1:0] data_in,
  output logic      [host_port_pkg::DMA_CH-1:0] dack_n,
  output logic                                  tc
);
  import host_port_pkg::*;
  logic [DATA_W-1:0] wd_q;
  logic              wen_q;
  int                tmo_cnt = 0;
  // Released bus shows the inverse of the last value, never a copy
  assign data_in = data_oe ? data_out : (wen_q ? wd_q : ~wd_q);
  initial begin
    addr = '0;
    ior_n = 1'b1;
    iow_n = 1'b1;
    aen = 1'b0;
    cs_n = 1'b0;
    dack_n = '1;
    tc = 1'b0;
    wd_q = '0;
    wen_q = 1'b0;
  end
  task automatic set_dma(input logic a, input logic [DMA_CH-1:0] k,
      input logic t, input logic c);
    @(negedge mclk);
    aen = a;
    dack_n = k;
    tc = t;
    cs_n = c;
  endtask : set_dma
  // One cycle; strobe held longer while ready is pulled low
  task automatic cycle(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd,
      output logic drove, output logic stretched);
    int n;
    drove = 1'b0;
    stretched = 1'b0;
    rd = '0;
    n = 0;
    @(negedge mclk);
    addr = a;
    wd_q = wd;
    wen_q = wr;
    ior_n = wr;
    iow_n = !wr;
    while (n < 8 || (iochrdy_oe && n < 64)) begin
      @(negedge mclk);
      if (data_oe) begin
        drove = 1'b1;
        rd = data_out;
      end
      if (iochrdy_oe)
        stretched = 1'b1;
      n++;
    end
    if (iochrdy_oe)
      tmo_cnt++;
    ior_n = 1'b1;
    iow_n = 1'b1;
    wen_q = 1'b0;
    repeat (6) @(negedge mclk);
  endtask : cycle
endmodule : host_model

/* verification/tb.sv */
/*
  Self-checking bench for the ISA host port.
  Assumes host_model as the host side; function side driven here.
*/
`timescale 1ns/100ps
module tb;
  import host_port_pkg::*;
  logic mclk = 1'b0, srst = 1'b1, ior_n, iow_n, aen, cs_n, tc;
  logic [ADDR_W-1:0] addr, fn_addr, win_base = 11'h3F5, win_mask = '1;
  logic [DATA_W-1:0] data_in, data_out, fn_wdata, rd;
  logic [DATA_W-1:0] fn_rdata = 8'hA5;
  logic [DMA_CH-1:0] drq, dack_n, fn_dma_en, fn_tc;
  logic [DMA_CH-1:0] fn_dma_want = '0, fn_dma_last = '0;
  logic [IRQ_OUTS-1:0] irq_out, irq_oe;
  logic [IRQ_SRCS*IRQ_SEL_W-1:0] irq_sel = {8{3'h7}};
  logic [IRQ_SRCS-2:0] fn_irq = '0;
  logic data_oe, iochrdy_out, iochrdy_oe, fn_sel, fn_rd_pulse, fn_wr_pulse;
  logic external_interrupt_input = 1'b0, ir_wait = 1'b0, epp_wait = 1'b0;
  logic drove, str;
  tc_mode_t tc_mode = TC_MODE_AT;
  par_mode_t par_mode = PAR_SPP;
  int errors = 0, cmp_count = 0, sel_cnt = 0, wr_cnt = 0, dlo_cnt = 0;
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    sel_cnt <= sel_cnt + int'(fn_sel);
    wr_cnt <= wr_cnt + int'(fn_wr_pulse);
    dlo_cnt <= dlo_cnt + int'(fn_dma_want[0] && !drq[0]);
  end
  isa_host_bus_interface isa_host_bus_interface_i (.mclk, .srst, .addr,
    .ior_n, .iow_n, .aen, .cs_n, .data_in, .data_out, .data_oe, .drq,
    .dack_n, .tc, .irq_out, .irq_oe, .external_interrupt_input,
    .iochrdy_out, .iochrdy_oe, .tc_mode, .par_mode, .irq_sel, .win_base,
    .win_mask, .fn_addr, .fn_sel, .fn_rd_pulse, .fn_wr_pulse, .fn_wdata,
    .fn_rdata, .fn_irq, .fn_dma_want, .fn_dma_last, .fn_dma_en, .fn_tc,
    .ir_wait, .epp_wait);
  host_model host_model_i (.mclk, .data_out, .data_oe, .iochrdy_oe, .addr,
    .ior_n, .iow_n, .aen, .cs_n, .data_in, .dack_n, .tc);
  task automatic check(input string what, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic t_access;
    int w;
    host_model_i.cycle(1'b0, 11'h3F5, 8'h00, rd, drove, str);
    check("read drive", {7'h0, drove, rd}, 16'h01A5);
    check("addr held", 16'(fn_addr), 16'h03F5);
    check("oe idle", 16'(data_oe), 16'h0000);
    w = wr_cnt;
    host_model_i.cycle(1'b1, 11'h3F5, 8'h5A, rd, drove, str);
    check("write data", 16'(fn_wdata), 16'h005A);
    check("one pulse", 16'(wr_cnt - w), 16'h0001);
  endtask : t_access
  task automatic t_refuse;
    int s;
    for (int k = 0; k < 4; k++) begin
      host_model_i.set_dma(k == 0, '1, 1'b0, k == 1);
      s = sel_cnt;
      host_model_i.cycle(1'b0, 11'h3F5 ^ (k == 2 ? 11'h400 : 11'h000)
        ^ 11'(k == 3), 8'h00, rd, drove, str);
      check("refused", 16'(sel_cnt - s) + 16'(drove), 16'h0000);
    end
    host_model_i.set_dma(1'b0, '1, 1'b0, 1'b0);
  endtask : t_refuse
  task automatic t_dma;
    int d, s;
    @(negedge mclk);
    fn_dma_want = 3'h1;
    fn_dma_last = 3'h1;
    repeat (3) @(negedge mclk);
    check("drq up", 16'({drq, fn_dma_en}), 16'h0008);
    host_model_i.set_dma(1'b1, 3'h6, 1'b0, 1'b0);
    repeat (3) @(negedge mclk);
    check("drq ack", 16'({drq, fn_dma_en}), 16'h0001);
    fn_dma_want = 3'h3;
    repeat (3) @(negedge mclk);
    check("demand up", 16'(drq), 16'h0003);
    d = dlo_cnt;
    s = sel_cnt;
    host_model_i.cycle(1'b0, 11'h3F5, 8'h00, rd, drove, str);
    check("dma read", {7'h0, drove, rd}, 16'h01A5);
    check("demand drop", 16'(dlo_cnt - d), 16'h0001);
    check("dma no decode", 16'(sel_cnt - s), 16'h0000);
    fn_dma_want = '0;
    fn_dma_last = '0;
    host_model_i.set_dma(1'b0, '1, 1'b0, 1'b0);
  endtask : t_dma
  task automatic t_tc(input tc_mode_t m, input logic act);
    tc_mode = m;
    srst = 1'b1;
    repeat (RESET_MIN_CYC) @(negedge mclk);
    srst = 1'b0;
    check("reset", 16'({drq, iochrdy_oe, data_oe, irq_oe}), 16'h0);
    fn_dma_want = 3'h2;
    host_model_i.set_dma(1'b0, '1, act, 1'b0);
    repeat (5) @(negedge mclk);
    check("tc no ack", 16'(fn_tc), 16'h0000);
    host_model_i.set_dma(1'b1, 3'h5, act, 1'b0);
    repeat (5) @(negedge mclk);
    check("tc ack", 16'(fn_tc), 16'h0002);
    host_model_i.set_dma(1'b0, '1, !act, 1'b0);
    fn_dma_want = '0;
  endtask : t_tc
  task automatic t_irq;
    int low;
    low = 0;
    irq_sel[21+:3] = 3'h2;
    irq_sel[9+:3] = 3'h0;
    external_interrupt_input = 1'b1;
    repeat (3) @(negedge mclk);
    check("steer", 16'(irq_oe & irq_out), 16'h0004);
    external_interrupt_input = 1'b0;
    par_mode = PAR_EPP;
    fn_irq[3] = 1'b1;
    repeat (12) begin
      @(negedge mclk);
      low += int'(irq_oe[0] && !irq_out[0]);
    end
    check("share pulse", 16'({irq_oe[0], low != 0}), 16'h0001);
    check("pulse len", 16'(low), 16'(IRQ_PULSE_CYC));
    fn_irq[3] = 1'b0;
  endtask : t_irq
  task automatic t_ready;
    ir_wait = 1'b1;
    fork
      host_model_i.cycle(1'b0, 11'h3F5, 8'h00, rd, drove, str);
      begin
        repeat (14) @(negedge mclk);
        ir_wait = 1'b0;
      end
    join
    check("ir stretch", 16'(str), 16'h0001);
    ir_wait = 1'b0;
    epp_wait = 1'b1;
    par_mode = PAR_SPP;
    host_model_i.cycle(1'b0, 11'h3F5, 8'h00, rd, drove, str);
    check("spp no stretch", 16'(str), 16'h0000);
    par_mode = PAR_EPP;
    fork
      host_model_i.cycle(1'b1, 11'h3F5, 8'h11, rd, drove, str);
      begin
        repeat (14) @(negedge mclk);
        epp_wait = 1'b0;
      end
    join
    check("epp stretch", 16'(str), 16'h0001);
    epp_wait = 1'b0;
  endtask : t_ready
  task automatic print_verdict;
    check("timeout", 16'(host_model_i.tmo_cnt), 16'h0000);
    if (errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (10) @(negedge mclk);
    srst = 1'b0;
    repeat (4) @(negedge mclk);
    t_access();
    t_refuse();
    t_dma();
    t_tc(TC_MODE_AT, 1'b1);
    t_tc(TC_MODE_MODEL30, 1'b1);
    t_tc(TC_MODE_PS, 1'b0);
    t_irq();
    t_ready();
    print_verdict();
  end
endmodule : tb
